// ===== rtl/vaesr_map.svh
`ifndef VAESR_MAP_SVH
`define VAESR_MAP_SVH

// ---------------------------------------------
// element and group geometry
// ---------------------------------------------
`define VAESR_SEW_32 3'h2
`define VAESR_EGW 128
`define VAESR_EGS_LOG2 2
`define VAESR_REGISTER_GROUP_MULTIPLIER_RSVD 3'h4
`define VAESR_REGISTER_GROUP_MULTIPLIER_FRAC_BASE 8

// ---------------------------------------------
// key schedule round number
// ---------------------------------------------
`define VAESR_RND_MAX 4'hA
`define VAESR_RND_ZERO 4'h0
`define VAESR_RND_FLIP_BIT 3
`define VAESR_RCON_INIT 8'h01
`define VAESR_XTIME 8'h02

// ---------------------------------------------
// field arithmetic and byte transforms
// ---------------------------------------------
`define VAESR_GF_POLY 8'h1b
`define VAESR_GF_INV_EXP 8'hfe
`define VAESR_SBOX_FWD_C 8'h63
`define VAESR_SBOX_INV_C 8'h05
`define VAESR_MIX_FWD 32'h0101_0302
`define VAESR_MIX_INV 32'h090d_0b0e

`endif

// ===== rtl/vaesr_pkg.sv
package vaesr_pkg;

`include "vaesr_map.svh"

	typedef enum logic [2:0] {
		VAESR_OP_DEC_FINAL = 3'h0,
		VAESR_OP_DEC_MID = 3'h1,
		VAESR_OP_ENC_FINAL = 3'h2,
		VAESR_OP_ENC_MID = 3'h3,
		VAESR_OP_KEY128 = 3'h4
	} vaesr_op_t;

	typedef enum logic [4:0] {
		VAESR_ST_IDLE = 5'h01,
		VAESR_ST_READ = 5'h02,
		VAESR_ST_WAIT = 5'h04,
		VAESR_ST_WRITE = 5'h08,
		VAESR_ST_DONE = 5'h10
	} vaesr_state_t;

	function automatic logic [7:0] vaesr_gf_mul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				p = p ^ x;
			end
			x = x[7] ? ({x[6:0], 1'b0} ^ `VAESR_GF_POLY) : {x[6:0], 1'b0};
		end
		return p;
	endfunction : vaesr_gf_mul

	// x^254 is the field inverse and maps zero to zero, as the s-box wants
	function automatic logic [7:0] vaesr_gf_inv(input logic [7:0] x);
		logic [7:0] r;
		logic [7:0] e;
		r = `VAESR_RCON_INIT;
		e = `VAESR_GF_INV_EXP;
		for (int i = 7; i >= 0; i--) begin
			r = vaesr_gf_mul(r, r);
			if (e[i]) begin
				r = vaesr_gf_mul(r, x);
			end
		end
		return r;
	endfunction : vaesr_gf_inv

endpackage : vaesr_pkg

// ===== rtl/vaesr_sbox.sv
`timescale 1ns/100ps
`include "vaesr_map.svh"

module vaesr_sbox import vaesr_pkg::*; (
	// byte in
	input wire logic [7:0] din,
	input wire logic inverse,
	// byte out
	output logic [7:0] dout
);

	function automatic logic [7:0] rotl8(input logic [7:0] b, input int n);
		logic [15:0] t;
		t = {8'h00, b} << n;
		return t[7:0] | t[15:8];
	endfunction : rotl8

	logic [7:0] pre;
	logic [7:0] inv;

	// one shared inversion: the inverse affine runs before it, the forward after
	always_comb begin
		pre = inverse ? (rotl8(din, 1) ^ rotl8(din, 3) ^ rotl8(din, 6) ^ `VAESR_SBOX_INV_C) : din;
		inv = vaesr_gf_inv(pre);
		if (inverse) begin
			dout = inv;
		end else begin
			dout = inv ^ rotl8(inv, 1) ^ rotl8(inv, 2) ^ rotl8(inv, 3) ^ rotl8(inv, 4)
				^ `VAESR_SBOX_FWD_C;
		end
	end

endmodule : vaesr_sbox

// ===== rtl/vaesr_mixcol.sv
`timescale 1ns/100ps
`include "vaesr_map.svh"

module vaesr_mixcol import vaesr_pkg::*; (
	// column in, byte 0 in the low bits
	input wire logic [31:0] col,
	input wire logic inverse,
	// column out
	output logic [31:0] dout
);

	logic [31:0] coef;
	logic [7:0] acc;

	// coefficient k-r of the circulant matrix multiplies byte k for row r
	always_comb begin
		coef = inverse ? `VAESR_MIX_INV : `VAESR_MIX_FWD;
		dout = 32'h0000_0000;
		acc = 8'h00;
		for (int r = 0; r < 4; r++) begin
			acc = 8'h00;
			for (int k = 0; k < 4; k++) begin
				acc = acc ^ vaesr_gf_mul(coef[((k - r + 4) % 4) * 8 +: 8], col[k * 8 +: 8]);
			end
			dout[r * 8 +: 8] = acc;
		end
	end

endmodule : vaesr_mixcol

// ===== rtl/vaesr_round_unit.sv
`timescale 1ns/100ps
`include "vaesr_map.svh"


module vaesr_round_unit import vaesr_pkg::*; #(
	parameter int VECTOR_REGISTER_LENGTH = 128,
	parameter int VL_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// instruction issue from decode
	input wire logic op_valid,
	input wire vaesr_op_t op_code,
	input wire logic op_scalar_key,
	input wire logic [2:0] op_sew,
	input wire logic [2:0] op_vlmul,
	input wire logic [4:0] op_dest_reg,
	input wire logic [4:0] op_src_reg,
	input wire logic [VL_W-1:0] op_vstart,
	input wire logic [VL_W-1:0] op_vl,
	input wire logic [4:0] op_uimm,
	// register file read, data one cycle after the request
	output logic rd_en_q,
	output logic [VL_W-`VAESR_EGS_LOG2-1:0] rd_state_idx_q,
	output logic [VL_W-`VAESR_EGS_LOG2-1:0] rd_key_idx_q,
	input wire logic [`VAESR_EGW-1:0] rd_state_data,
	input wire logic [`VAESR_EGW-1:0] rd_key_data,
	// register file write
	output logic wr_en_q,
	output logic [VL_W-`VAESR_EGS_LOG2-1:0] wr_idx_q,
	output logic [`VAESR_EGW-1:0] wr_data_q,
	// status towards retire
	output logic busy_q,
	output logic done_q,
	output logic illegal_q,
	output logic reserved_q
);

	localparam int EGI_W = VL_W - `VAESR_EGS_LOG2;
	localparam int KEY_REGS = (VECTOR_REGISTER_LENGTH >= `VAESR_EGW) ? 1
		: `VAESR_EGW / VECTOR_REGISTER_LENGTH;

	if (VECTOR_REGISTER_LENGTH < 32 || VL_W < 3 || VL_W > 24
		|| (VECTOR_REGISTER_LENGTH & (VECTOR_REGISTER_LENGTH - 1)) != 0) begin : g_chk
		$error("vaesr_round_unit: unsupported register length or length width");
	end

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic int group_bits(input logic [2:0] vlmul);
		if (vlmul[2]) begin
			return VECTOR_REGISTER_LENGTH >> (`VAESR_REGISTER_GROUP_MULTIPLIER_FRAC_BASE - int'(vlmul));
		end
		return VECTOR_REGISTER_LENGTH << vlmul;
	endfunction : group_bits

	function automatic logic [127:0] shift_rows(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		int src;
		o = '0;
		src = 0;
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 4; r++) begin
				src = inv ? (c - r + 4) % 4 : (c + r) % 4;
				o[(c * 4 + r) * 8 +: 8] = s[(src * 4 + r) * 8 +: 8];
			end
		end
		return o;
	endfunction : shift_rows

	function automatic logic [7:0] round_const(input logic [3:0] n);
		logic [7:0] r;
		r = `VAESR_RCON_INIT;
		for (int i = 0; i < 16; i++) begin
			if (i < int'(n)) begin
				r = vaesr_gf_mul(r, `VAESR_XTIME);
			end
		end
		return r;
	endfunction : round_const

	// ---------------------------------------------
	// state
	// ---------------------------------------------
	vaesr_state_t state_q;
	vaesr_state_t state_d;
	vaesr_op_t op_q;
	logic scalar_q;
	logic scalar_d;
	logic [3:0] rcon_idx_q;
	logic [EGI_W-1:0] idx_q;
	logic [EGI_W-1:0] idx_d;
	logic [EGI_W-1:0] end_q;

	// ---------------------------------------------
	// issue checks
	// ---------------------------------------------
	logic accept;
	logic sew_bad;
	logic overlap;
	logic grp_small;
	logic fault;
	logic [EGI_W-1:0] eg_start;
	logic [EGI_W-1:0] eg_end;
	logic [5:0] d_hi;
	logic [5:0] s_hi;
	logic [3:0] dest_regs;
	logic [3:0] rnd;

	assign accept = (state_q == VAESR_ST_IDLE) && op_valid;

	always_comb begin
		sew_bad = (op_sew != `VAESR_SEW_32);
		dest_regs = op_vlmul[2] ? 4'h1 : 4'(4'h1 << op_vlmul[1:0]);
		d_hi = 6'({1'b0, op_dest_reg} + dest_regs - 1'b1);
		s_hi = 6'({1'b0, op_src_reg} + KEY_REGS - 1);
		overlap = op_scalar_key && (op_code != VAESR_OP_KEY128)
			&& ({1'b0, op_dest_reg} <= s_hi) && ({1'b0, op_src_reg} <= d_hi);
		grp_small = (op_vlmul == `VAESR_REGISTER_GROUP_MULTIPLIER_RSVD)
			|| (group_bits(op_vlmul) < `VAESR_EGW);
		fault = sew_bad || overlap || grp_small;
		eg_start = EGI_W'(op_vstart >> `VAESR_EGS_LOG2);
		eg_end = EGI_W'(op_vl >> `VAESR_EGS_LOG2);
		rnd = op_uimm[3:0];
		if (rnd > `VAESR_RND_MAX || rnd == `VAESR_RND_ZERO) begin
			rnd[`VAESR_RND_FLIP_BIT] = ~rnd[`VAESR_RND_FLIP_BIT];
		end
	end

	// ---------------------------------------------
	// sequencing
	// ---------------------------------------------
	// every group costs read, wait, write whatever the data: fixed latency
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			VAESR_ST_IDLE: begin
				if (op_valid) begin
					state_d = (!fault && eg_start < eg_end) ? VAESR_ST_READ : VAESR_ST_DONE;
				end
			end
			VAESR_ST_READ: state_d = VAESR_ST_WAIT;
			VAESR_ST_WAIT: state_d = VAESR_ST_WRITE;
			VAESR_ST_WRITE: begin
				state_d = (EGI_W'(idx_q + 1'b1) < end_q) ? VAESR_ST_READ : VAESR_ST_DONE;
			end
			VAESR_ST_DONE: state_d = VAESR_ST_IDLE;
			default: state_d = VAESR_ST_IDLE;
		endcase
	end

	always_comb begin
		idx_d = idx_q;
		scalar_d = scalar_q;
		if (accept) begin
			idx_d = eg_start;
			scalar_d = op_scalar_key && (op_code != VAESR_OP_KEY128);
		end else if (state_q == VAESR_ST_WRITE) begin
			idx_d = EGI_W'(idx_q + 1'b1);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= VAESR_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			op_q <= VAESR_OP_DEC_FINAL;
			scalar_q <= 1'b0;
			rcon_idx_q <= 4'h0;
			idx_q <= '0;
			end_q <= '0;
		end else begin
			idx_q <= idx_d;
			scalar_q <= scalar_d;
			if (accept) begin
				op_q <= op_code;
				rcon_idx_q <= 4'(rnd - 1'b1);
				end_q <= eg_end;
			end
		end
	end

	// ---------------------------------------------
	// register file read
	// ---------------------------------------------
	// a group is read in full before its own write, so vd may alias vs2 unless a round op takes a scalar key (overlap is then reserved)
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_en_q <= 1'b0;
			rd_state_idx_q <= '0;
			rd_key_idx_q <= '0;
		end else begin
			rd_en_q <= (state_d == VAESR_ST_READ);
			if (state_d == VAESR_ST_READ) begin
				rd_state_idx_q <= idx_d;
				rd_key_idx_q <= scalar_d ? '0 : idx_d;
			end
		end
	end

	// ---------------------------------------------
	// round datapath
	// ---------------------------------------------
	logic dec;
	logic [127:0] shifted;
	logic [127:0] subbed;
	logic [127:0] mix_in;
	logic [127:0] mixed;
	logic [31:0] key_rot;
	logic [31:0] key_sub;
	logic [31:0] kw [4];
	logic [127:0] result;

	// substitution is bytewise, so shifting first serves both directions
	assign dec = (op_q == VAESR_OP_DEC_FINAL) || (op_q == VAESR_OP_DEC_MID);
	assign shifted = shift_rows(rd_state_data, dec);
	assign key_rot = {rd_key_data[103:96], rd_key_data[127:104]};

	for (genvar b = 0; b < 16; b++) begin : g_sb
		vaesr_sbox u_sbox (
			.din(shifted[b * 8 +: 8]),
			.inverse(dec),
			.dout(subbed[b * 8 +: 8])
		);
	end

	for (genvar b = 0; b < 4; b++) begin : g_ksb
		vaesr_sbox u_sbox (
			.din(key_rot[b * 8 +: 8]),
			.inverse(1'b0),
			.dout(key_sub[b * 8 +: 8])
		);
	end

	// decrypt middle mixes after the key xor, encrypt middle before it
	assign mix_in = dec ? (subbed ^ rd_key_data) : subbed;

	for (genvar c = 0; c < 4; c++) begin : g_mix
		vaesr_mixcol u_mix (
			.col(mix_in[c * 32 +: 32]),
			.inverse(dec),
			.dout(mixed[c * 32 +: 32])
		);
	end

	always_comb begin
		kw[0] = key_sub ^ {24'h00_0000, round_const(rcon_idx_q)} ^ rd_key_data[31:0];
		kw[1] = kw[0] ^ rd_key_data[63:32];
		kw[2] = kw[1] ^ rd_key_data[95:64];
		kw[3] = kw[2] ^ rd_key_data[127:96];
		unique case (op_q)
			VAESR_OP_DEC_FINAL: result = subbed ^ rd_key_data;
			VAESR_OP_DEC_MID: result = mixed;
			VAESR_OP_ENC_FINAL: result = subbed ^ rd_key_data;
			VAESR_OP_ENC_MID: result = mixed ^ rd_key_data;
			VAESR_OP_KEY128: result = {kw[3], kw[2], kw[1], kw[0]};
			default: result = '0;
		endcase
	end

	// ---------------------------------------------
	// register file write
	// ---------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_en_q <= 1'b0;
			wr_idx_q <= '0;
			wr_data_q <= '0;
		end else begin
			wr_en_q <= (state_q == VAESR_ST_WAIT);
			if (state_q == VAESR_ST_WAIT) begin
				wr_idx_q <= idx_q;
				wr_data_q <= result;
			end
		end
	end

	// ---------------------------------------------
	// status
	// ---------------------------------------------
	// illegal and reserved stand until the next accepted instruction; reserved wins over illegal
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			illegal_q <= 1'b0;
			reserved_q <= 1'b0;
		end else begin
			busy_q <= (state_d != VAESR_ST_IDLE);
			done_q <= (state_d == VAESR_ST_DONE);
			if (accept) begin
				reserved_q <= sew_bad || overlap;
				illegal_q <= !(sew_bad || overlap) && grp_small;
			end
		end
	end

endmodule : vaesr_round_unit

// ===== testbench/vaesr_round_unit_sva.sv
`timescale 1ns/100ps

module vaesr_round_unit_sva import vaesr_pkg::*; #(
	parameter int VL_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// issue
	input wire logic op_valid,
	input wire vaesr_op_t op_code,
	input wire logic op_scalar_key,
	input wire logic [2:0] op_sew,
	input wire logic [2:0] op_vlmul,
	input wire logic [4:0] op_dest_reg,
	input wire logic [4:0] op_src_reg,
	input wire logic [VL_W-1:0] op_vstart,
	input wire logic [VL_W-1:0] op_vl,
	// register file
	input wire logic rd_en_q,
	input wire logic [VL_W-3:0] rd_state_idx_q,
	input wire logic [VL_W-3:0] rd_key_idx_q,
	input wire logic wr_en_q,
	input wire logic [VL_W-3:0] wr_idx_q,
	// status
	input wire logic busy_q,
	input wire logic done_q,
	input wire logic illegal_q,
	input wire logic reserved_q
);
	logic acc;
	logic ovl;
	logic ok;
	logic sk_q;
	logic [VL_W-3:0] end_q;

	assign acc = op_valid && !busy_q;
	assign ovl = op_scalar_key && op_code != VAESR_OP_KEY128
		&& ({1'b0, op_src_reg} - {1'b0, op_dest_reg}) < (6'h01 << op_vlmul);
	assign ok = op_sew == 3'h2 && !op_vlmul[2] && !ovl;

	always_ff @(posedge clk) begin
		if (acc) begin
			sk_q <= op_scalar_key && op_code != VAESR_OP_KEY128;
			end_q <= op_vl[VL_W-1:2];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_sew_reserved: assert property (
		acc && op_sew != 3'h2 |=> done_q && reserved_q && !rd_en_q)
		else $error("element width fault missing");
	a_scalar_overlap: assert property (
		acc && op_sew == 3'h2 && !op_vlmul[2] && ovl |=> reserved_q)
		else $error("key overlap not reserved");
	a_group_illegal: assert property (
		acc && op_sew == 3'h2 && op_vlmul[2] && !op_scalar_key
		|=> done_q && illegal_q && !reserved_q)
		else $error("short group not illegal");
	a_first_group: assert property (
		acc && ok && op_vstart[VL_W-1:2] < op_vl[VL_W-1:2]
		|=> rd_en_q && rd_state_idx_q == $past(op_vstart[VL_W-1:2]))
		else $error("wrong first group");
	a_empty_range: assert property (
		acc && ok && op_vstart[VL_W-1:2] >= op_vl[VL_W-1:2]
		|=> done_q && !rd_en_q && !illegal_q && !reserved_q)
		else $error("empty range misbehaves");
	a_fixed_latency: assert property (
		rd_en_q |=> !rd_en_q && !wr_en_q
		##1 wr_en_q && wr_idx_q == $past(rd_state_idx_q, 2))
		else $error("write timing or index wrong");
	a_key_index: assert property (
		rd_en_q |-> rd_key_idx_q == (sk_q ? '0 : rd_state_idx_q))
		else $error("wrong key group");
	a_last_done: assert property (
		wr_en_q && wr_idx_q == end_q - 1'b1 |=> done_q && !rd_en_q)
		else $error("no done after last group");
	a_next_group: assert property (
		wr_en_q && wr_idx_q != end_q - 1'b1
		|=> rd_en_q && rd_state_idx_q == $past(wr_idx_q) + 1'b1)
		else $error("next group not read");
	a_done_pulse: assert property (done_q |=> !done_q && !busy_q)
		else $error("done not a single pulse");

	c_good_op: cover property (acc && ok);
	c_scalar_write: cover property (wr_en_q && sk_q);
	c_illegal: cover property (done_q && illegal_q);
endmodule : vaesr_round_unit_sva

bind vaesr_round_unit vaesr_round_unit_sva #(.VL_W(VL_W)) u_vaesr_round_unit_sva (
	.clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
	.op_scalar_key(op_scalar_key), .op_sew(op_sew), .op_vlmul(op_vlmul),
	.op_dest_reg(op_dest_reg), .op_src_reg(op_src_reg), .op_vstart(op_vstart),
	.op_vl(op_vl), .rd_en_q(rd_en_q), .rd_state_idx_q(rd_state_idx_q),
	.rd_key_idx_q(rd_key_idx_q), .wr_en_q(wr_en_q), .wr_idx_q(wr_idx_q),
	.busy_q(busy_q), .done_q(done_q), .illegal_q(illegal_q), .reserved_q(reserved_q)
);

// ===== testbench/vaesr_vrf_model.sv
`timescale 1ns/100ps

module vaesr_vrf_model import vaesr_pkg::*; #(
	parameter int VL_W = 16
) (
	// clock
	input wire logic clk,
	// read port
	input wire logic rd_en_q,
	input wire logic [VL_W-3:0] rd_state_idx_q,
	input wire logic [VL_W-3:0] rd_key_idx_q,
	output logic [127:0] rd_state_data,
	output logic [127:0] rd_key_data,
	// write port
	input wire logic wr_en_q,
	input wire logic [VL_W-3:0] wr_idx_q,
	input wire logic [127:0] wr_data_q
);
	logic [127:0] st [0:7];
	logic [127:0] ky [0:7];
	int writes;

	initial begin
		rd_state_data = '0;
		rd_key_data = '0;
		writes = 0;
	end

	// data holds only in the cycle after a request; else the stale value flips
	always @(posedge clk) begin
		if (rd_en_q) begin
			rd_state_data <= st[rd_state_idx_q[2:0]];
			rd_key_data <= ky[rd_key_idx_q[2:0]];
		end else begin
			rd_state_data <= ~rd_state_data;
			rd_key_data <= ~rd_key_data;
		end
		if (wr_en_q) begin
			st[wr_idx_q[2:0]] <= wr_data_q;
			writes <= writes + 1;
		end
	end
endmodule : vaesr_vrf_model

// ===== testbench/testbench.sv
`timescale 1ns/100ps

module testbench import vaesr_pkg::*;;
	// byte strings in textbook order, first byte leftmost
	localparam logic [127:0] START = 128'h193d_e3be_a0f4_e22b_9ac6_8d2a_e9f8_4808;
	localparam logic [127:0] SROW = 128'hd4bf_5d30_e0b4_52ae_b841_11f1_1e27_98e5;
	localparam logic [127:0] MCOL = 128'h0466_81e5_e0cb_199a_48f8_d37a_2806_264c;
	localparam logic [127:0] RK1 = 128'ha0fa_fe17_8854_2cb1_23a3_3939_2a6c_7605;
	localparam logic [127:0] NEXT = 128'ha49c_7ff2_689f_352b_6b5b_ea43_026a_5049;
	localparam logic [127:0] KEY0 = 128'h2b7e_1516_28ae_d2a6_abf7_1588_09cf_4f3c;
	logic clk, reset, op_valid, op_scalar_key;
	vaesr_op_t op_code;
	logic [2:0] op_sew, op_vlmul;
	logic [4:0] op_dest_reg, op_src_reg, op_uimm;
	logic [15:0] op_vstart, op_vl;
	logic rd_en_q, wr_en_q, busy_q, done_q, illegal_q, reserved_q;
	logic [13:0] rd_state_idx_q, rd_key_idx_q, wr_idx_q;
	logic [127:0] rd_state_data, rd_key_data, wr_data_q, sv;
	int errors, comparisons, lat, w;

	vaesr_round_unit u_vaesr_round_unit (.clk(clk), .reset(reset), .op_valid(op_valid),
		.op_code(op_code), .op_scalar_key(op_scalar_key), .op_sew(op_sew), .op_vlmul(op_vlmul),
		.op_dest_reg(op_dest_reg), .op_src_reg(op_src_reg), .op_vstart(op_vstart),
		.op_vl(op_vl), .op_uimm(op_uimm), .rd_en_q(rd_en_q), .rd_state_idx_q(rd_state_idx_q),
		.rd_key_idx_q(rd_key_idx_q), .rd_state_data(rd_state_data), .rd_key_data(rd_key_data),
		.wr_en_q(wr_en_q), .wr_idx_q(wr_idx_q), .wr_data_q(wr_data_q), .busy_q(busy_q),
		.done_q(done_q), .illegal_q(illegal_q), .reserved_q(reserved_q));
	vaesr_vrf_model u_vaesr_vrf_model (.clk(clk), .rd_en_q(rd_en_q),
		.rd_state_idx_q(rd_state_idx_q), .rd_key_idx_q(rd_key_idx_q),
		.rd_state_data(rd_state_data), .rd_key_data(rd_key_data), .wr_en_q(wr_en_q),
		.wr_idx_q(wr_idx_q), .wr_data_q(wr_data_q));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// byte 0 of the state sits in the low bits of element 0
	function automatic logic [127:0] sw(input logic [127:0] b);
		logic [127:0] r;
		for (int i = 0; i < 16; i++) begin
			r[8*i +: 8] = b[127-8*i -: 8];
		end
		return r;
	endfunction : sw

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic ld(input logic [127:0] s0, s1, k0, k1);
		for (int i = 0; i < 8; i++) begin
			u_vaesr_vrf_model.st[i] = sw(i == 0 ? s0 : s1);
			u_vaesr_vrf_model.ky[i] = sw(i == 0 ? k0 : k1);
		end
	endtask : ld

	// issue one op and count cycles from the accept edge to done
	task automatic run(input vaesr_op_t c, input int vs, input int vl, input int im);
		@(posedge clk);
		#1;
		op_code = c;
		op_vstart = 16'(vs);
		op_vl = 16'(vl);
		op_uimm = 5'(im);
		op_valid = 1'b1;
		@(posedge clk);
		#1;
		op_valid = 1'b0;
		lat = 0;
		while (done_q !== 1'b1 && lat < 100) begin
			@(posedge clk);
			#1;
			lat++;
		end
		if (done_q !== 1'b1) begin
			errors++;
			$display("ERROR %0t: no done within limit", $time);
		end
	endtask : run

	task automatic t_rounds;
		ld(START, START, '0, RK1);
		run(VAESR_OP_ENC_MID, 0, 8, 0);
		chk(u_vaesr_vrf_model.st[0], sw(MCOL));
		chk(u_vaesr_vrf_model.st[1], sw(NEXT));
		chk(128'(lat), 128'h6);
		op_scalar_key = 1'b1;
		ld(START, START, '0, RK1);
		run(VAESR_OP_ENC_MID, 0, 8, 0);
		chk(u_vaesr_vrf_model.st[1], sw(MCOL));
		ld(START, SROW, '0, '0);
		run(VAESR_OP_ENC_FINAL, 0, 4, 0);
		chk(u_vaesr_vrf_model.st[0], sw(SROW));
		chk(u_vaesr_vrf_model.st[1], sw(SROW));
		op_scalar_key = 1'b0;
		ld(SROW, SROW, '0, MCOL ^ START);
		run(VAESR_OP_DEC_FINAL, 0, 4, 0);
		chk(u_vaesr_vrf_model.st[0], sw(START));
		// the expected state equals the loaded one, so the write count proves the write
		w = u_vaesr_vrf_model.writes;
		run(VAESR_OP_DEC_MID, 4, 8, 0);
		chk(u_vaesr_vrf_model.st[1], sw(SROW));
		chk(128'(u_vaesr_vrf_model.writes), 128'(w + 1));
		chk(u_vaesr_vrf_model.st[0], sw(START));
	endtask : t_rounds

	task automatic t_range;
		ld(MCOL, START, '0, '0);
		run(VAESR_OP_ENC_FINAL, 5, 15, 0);
		chk(u_vaesr_vrf_model.st[1], sw(SROW));
		chk(u_vaesr_vrf_model.st[2], sw(SROW));
		chk(u_vaesr_vrf_model.st[0], sw(MCOL));
		chk(u_vaesr_vrf_model.st[3], sw(START));
		chk(128'(lat), 128'h6);
		w = u_vaesr_vrf_model.writes;
		run(VAESR_OP_ENC_FINAL, 8, 8, 0);
		chk(128'(lat), 128'h0);
		chk(128'(u_vaesr_vrf_model.writes), 128'(w));
	endtask : t_range

	task automatic t_faults;
		w = u_vaesr_vrf_model.writes;
		for (int s = 0; s < 8; s++) begin
			op_sew = 3'(s);
			run(VAESR_OP_ENC_MID, 0, 8, 0);
			chk({reserved_q, illegal_q}, s == 2 ? 128'h0 : 128'h2);
		end
		op_sew = 3'h2;
		for (int m = 4; m < 8; m++) begin
			op_vlmul = 3'(m);
			run(VAESR_OP_DEC_MID, 0, 8, 0);
			chk({reserved_q, illegal_q, 8'(lat)}, 128'h100);
		end
		op_scalar_key = 1'b1;
		op_vlmul = 3'h3;
		op_src_reg = 5'h07;
		run(VAESR_OP_DEC_FINAL, 0, 8, 0);
		chk({reserved_q, illegal_q}, 128'h2);
		op_src_reg = 5'h08;
		run(VAESR_OP_DEC_FINAL, 0, 8, 0);
		chk({reserved_q, illegal_q}, 128'h0);
		chk(128'(u_vaesr_vrf_model.writes), 128'(w + 4));
		op_scalar_key = 1'b0;
		op_vlmul = 3'h0;
	endtask : t_faults

	task automatic t_keyexp;
		ld('0, '0, KEY0, KEY0);
		run(VAESR_OP_KEY128, 0, 4, 1);
		chk(u_vaesr_vrf_model.st[0], sw(RK1));
		u_vaesr_vrf_model.st[0] = '0;
		run(VAESR_OP_KEY128, 0, 4, 17);
		chk(u_vaesr_vrf_model.st[0], sw(RK1));
		for (int j = 0; j < 16; j++) begin
			if (j == 0 || j > 10) begin
				run(VAESR_OP_KEY128, 0, 4, j);
				sv = u_vaesr_vrf_model.st[0];
				run(VAESR_OP_KEY128, 0, 4, j ^ 8);
				chk(u_vaesr_vrf_model.st[0], sv);
			end
		end
	endtask : t_keyexp

	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		errors = 0;
		comparisons = 0;
		reset = 1'b1;
		op_valid = 1'b0;
		op_code = VAESR_OP_DEC_FINAL;
		op_scalar_key = 1'b0;
		op_sew = 3'h2;
		op_vlmul = 3'h0;
		op_dest_reg = 5'h00;
		op_src_reg = 5'h08;
		op_vstart = '0;
		op_vl = '0;
		op_uimm = '0;
		repeat (20) @(posedge clk);
		#1;
		reset = 1'b0;
		chk({busy_q, done_q, illegal_q, reserved_q, rd_en_q, wr_en_q}, 128'h0);
		t_rounds();
		t_range();
		t_faults();
		t_keyexp();
		report_and_stop();
	end

	initial begin
		#40000;
		errors++;
		$display("ERROR %0t: watchdog expired", $time);
		report_and_stop();
	end
endmodule : testbench
